// ==== rtl/swr_dev.sv ====
// Identity device end: identity code, command gating, fast mode, add-only memory.
//
// Contract
// - 64-bit identity: family, serial, check byte
// - Check byte uses x^8+x^5+x^4+1
// - Accumulator starts from all zeros
// - Family bits low first, then serial bits
// - Shifting in check byte leaves zero
// - Memory refused until identity command succeeds
// - Then one of five memory commands accepted
// - Fast-mode command byte switches to fast mode
// - Every byte travels low bit first
// - Programming only clears bits, never sets
// - Programming voltage on line raises detect
// - 256 pages of 256 bits, protectable
`timescale 1ns/100ps
`default_nettype none
`include "swr_link_regs.svh"
module swr_dev #(
  parameter logic [7:0]  FAMILY = `SWR_FAMILY_DEF,  // Arbitrary value
  parameter logic [47:0] SERIAL = `SWR_SERIAL_DEF   // Arbitrary value
) (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  swr_link_if.device       LNK,
  output logic             ID_OK,
  output logic             OD_MODE,
  output logic             VPP_DET,
  output logic             MEM_OK,
  output logic [7:0]       MEM_CMD,
  output logic             MEM_CMD_STB,
  input  wire logic        PRG_STB,
  input  wire logic        WP_STB,
  input  wire logic [12:0] PRG_ADDR,
  input  wire logic [7:0]  PRG_DATA,
  output logic             PRG_DONE,
  input  wire logic [12:0] RD_ADDR,
  output logic [7:0]       RD_DATA
);
  // Identity code, family in the low byte
  localparam logic [55:0] ID56 = {SERIAL, FAMILY};
  localparam logic [7:0]  IDCRC = swr_pkg::swr_crc_calc(ID56);
  localparam logic [63:0] ROM  = {IDCRC, ID56};

  swr_pkg::swr_dev_st_t st_r, st_nxt;   // Protocol state
  logic [5:0]   cnt_r, cnt_nxt;         // Bit counter
  logic [1:0]   ph_r, ph_nxt;           // Search phase
  logic [7:0]   sh_r, sh_nxt;           // Command shifter
  logic         od_r, od_nxt;           // Fast mode flag
  logic         mok_r, mok_nxt;         // Memory access granted
  logic [7:0]   cmd_r, cmd_nxt;         // Accepted memory command
  logic         stb_r, stb_nxt;         // Command strobe
  logic         tx_r;                   // Bit for next read slot
  logic         txen_r;                 // Device owns read slots
  logic [6:0]   chk_cnt_r;              // Self-check bit index
  logic [7:0]   acc_r;                  // Self-check accumulator
  logic         idok_r;                 // Self-check result
  logic         vpp_r;                  // Voltage detect
  logic [255:0] wp_r;                   // Page protect bits
  logic         done_r;                 // Program done pulse
  logic [7:0]   rd_r;                   // Read data
  logic [7:0]   mem [0:`SWR_MEM_BYTES-1];  // Data memory

  // Memory starts erased
  initial begin
    for (int i = 0; i < `SWR_MEM_BYTES; i++) begin
      mem[i] = `SWR_ERASED;
    end
  end

  // Link decode
  wire       rx        = LNK.dq;
  wire [7:0] rx_byte   = {rx, sh_r[7:1]};                  // Low bit first
  wire       byte_end  = (cnt_r[2:0] == `SWR_BYTE_LAST);
  wire       rom_end   = (cnt_r == `SWR_ROM_LAST);
  wire       rom_bit   = ROM[cnt_r];
  wire       is_read   = (rx_byte == `SWR_ROM_READ);
  wire       is_match  = (rx_byte == `SWR_ROM_MATCH);
  wire       is_search = (rx_byte == `SWR_ROM_SEARCH);
  wire       is_skip   = (rx_byte == `SWR_ROM_SKIP);
  wire       is_odskip = (rx_byte == `SWR_ROM_OD_SKIP);
  wire       is_odmat  = (rx_byte == `SWR_ROM_OD_MATCH);
  wire       mem_valid = (rx_byte == `SWR_MEM_READ) || (rx_byte == `SWR_MEM_CMD1) ||
                         (rx_byte == `SWR_MEM_CMD2) || (rx_byte == `SWR_MEM_CMD3) ||
                         (rx_byte == `SWR_MEM_CMD4);
  wire       chk_run   = (chk_cnt_r < 7'(`SWR_ROM_BITS));

  // Programming decode
  wire [7:0] page      = PRG_ADDR[`SWR_PAGE_HI:`SWR_PAGE_LO];
  wire       prg_ok    = PRG_STB && mok_r && vpp_r && !wp_r[page];
  wire       wp_ok     = WP_STB && mok_r && vpp_r;

  // Outputs
  assign LNK.dq_s_o    = tx_r;
  assign LNK.dq_s_oe_n = !(LNK.slot_r && txen_r);
  assign ID_OK         = idok_r;
  assign OD_MODE       = od_r;
  assign VPP_DET       = vpp_r;
  assign MEM_OK        = mok_r;
  assign MEM_CMD       = cmd_r;
  assign MEM_CMD_STB   = stb_r;
  assign PRG_DONE      = done_r;
  assign RD_DATA       = rd_r;

  // Protocol next state
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    ph_nxt  = ph_r;
    sh_nxt  = sh_r;
    od_nxt  = od_r;
    mok_nxt = mok_r;
    cmd_nxt = cmd_r;
    stb_nxt = 1'b0;
    if (LNK.bus_rst) begin
      // Reset pulse restarts and withdraws access
      st_nxt  = swr_pkg::SD_ROMCMD;
      cnt_nxt = 6'h00;
      ph_nxt  = 2'h0;
      mok_nxt = 1'b0;
    end else begin
      case (st_r)
        swr_pkg::SD_ROMCMD: begin
          if (LNK.slot_w) begin
            sh_nxt  = rx_byte;
            cnt_nxt = cnt_r + 6'h01;
            if (byte_end) begin
              // Whole identity command received
              cnt_nxt = 6'h00;
              if (is_odskip || is_odmat) begin
                od_nxt = 1'b1;
              end
              if (is_read) begin
                st_nxt = swr_pkg::SD_RDROM;
              end else if (is_match || is_odmat) begin
                st_nxt = swr_pkg::SD_MATCH;
              end else if (is_search) begin
                st_nxt = swr_pkg::SD_SEARCH;
              end else if (is_skip || is_odskip) begin
                st_nxt  = swr_pkg::SD_MEMCMD;
                mok_nxt = 1'b1;
              end else begin
                st_nxt = swr_pkg::SD_IDLE;
              end
            end
          end
        end
        swr_pkg::SD_RDROM: begin
          // Send identity, low bit first
          if (LNK.slot_r) begin
            cnt_nxt = cnt_r + 6'h01;
            if (rom_end) begin
              st_nxt  = swr_pkg::SD_MEMCMD;
              mok_nxt = 1'b1;
            end
          end
        end
        swr_pkg::SD_MATCH, swr_pkg::SD_SEARCH: begin
          // Search sends bit and complement before each compare
          if (LNK.slot_r && st_r == swr_pkg::SD_SEARCH && ph_r != 2'h2) begin
            ph_nxt = ph_r + 2'h1;
          end
          if (LNK.slot_w && (st_r == swr_pkg::SD_MATCH || ph_r == 2'h2)) begin
            ph_nxt  = 2'h0;
            cnt_nxt = cnt_r + 6'h01;
            if (rx != rom_bit) begin
              st_nxt = swr_pkg::SD_IDLE;
            end else if (rom_end) begin
              st_nxt  = swr_pkg::SD_MEMCMD;
              mok_nxt = 1'b1;
            end
          end
        end
        swr_pkg::SD_MEMCMD: begin
          if (LNK.slot_w) begin
            sh_nxt  = rx_byte;
            cnt_nxt = cnt_r + 6'h01;
            if (byte_end) begin
              // Only the five memory commands go on
              st_nxt  = mem_valid ? swr_pkg::SD_DONE : swr_pkg::SD_IDLE;
              cmd_nxt = mem_valid ? rx_byte : cmd_r;
              stb_nxt = mem_valid;
            end
          end
        end
        swr_pkg::SD_IDLE, swr_pkg::SD_DONE: begin
          st_nxt = st_r;
        end
        default: begin
          st_nxt = swr_pkg::SD_IDLE;
        end
      endcase
    end
  end

  // Protocol registers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r  <= swr_pkg::SD_IDLE;
      cnt_r <= 6'h00;
      ph_r  <= 2'h0;
      sh_r  <= `SWR_CRC_ZERO;
      od_r  <= 1'b0;
      mok_r <= 1'b0;
      cmd_r <= `SWR_CRC_ZERO;
      stb_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      ph_r  <= ph_nxt;
      sh_r  <= sh_nxt;
      od_r  <= od_nxt;
      mok_r <= mok_nxt;
      cmd_r <= cmd_nxt;
      stb_r <= stb_nxt;
    end
  end

  // Next read-slot bit, complement in search phase one
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_r   <= 1'b1;
      txen_r <= 1'b0;
    end else begin
      txen_r <= (st_r == swr_pkg::SD_RDROM) || (st_r == swr_pkg::SD_SEARCH && ph_r != 2'h2);
      tx_r   <= (st_r == swr_pkg::SD_SEARCH && ph_r == 2'h1) ? !rom_bit : rom_bit;
    end
  end

  // Identity self-check after reset
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      chk_cnt_r <= 7'h00;
      acc_r     <= `SWR_CRC_ZERO;
      idok_r    <= 1'b0;
    end else if (chk_run) begin
      chk_cnt_r <= chk_cnt_r + 7'h01;
      acc_r     <= swr_pkg::swr_crc_step(acc_r, ROM[chk_cnt_r[5:0]]);
    end else begin
      idok_r    <= (acc_r == `SWR_CRC_ZERO);
    end
  end

  // Voltage detect and page protection
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      vpp_r  <= 1'b0;
      wp_r   <= '0;
      done_r <= 1'b0;
    end else begin
      vpp_r  <= LNK.vpp;
      done_r <= prg_ok;
      if (wp_ok) begin
        wp_r[page] <= 1'b1;
      end
    end
  end

  // Add-only memory: bits only fall to zero
  always_ff @(posedge CLK) begin
    if (prg_ok) begin
      mem[PRG_ADDR] <= mem[PRG_ADDR] & PRG_DATA;
    end
    rd_r <= mem[RD_ADDR];
  end
endmodule
`default_nettype wire

// ==== include/swr_link_regs.svh ====
// Named constants for the single-wire identity link: codes, sizes and timing.
`ifndef SWR_LINK_REGS_SVH
`define SWR_LINK_REGS_SVH

// Identity layout
`define SWR_ROM_BITS      64
`define SWR_ID_BITS       56
`define SWR_ROM_LAST      6'h3F
`define SWR_BYTE_LAST     3'h7
`define SWR_CRC_ZERO      8'h00
`define SWR_CRC_POLY_REV  8'h8C
`define SWR_FAMILY_DEF    8'hA5
`define SWR_SERIAL_DEF    48'h0123456789AB

// Identity function commands
`define SWR_ROM_READ      8'h01
`define SWR_ROM_MATCH     8'h02
`define SWR_ROM_SEARCH    8'h03
`define SWR_ROM_SKIP      8'h04
`define SWR_ROM_OD_SKIP   8'h05
`define SWR_ROM_OD_MATCH  8'h06

// Memory function commands
`define SWR_MEM_READ      8'hF0
`define SWR_MEM_CMD1      8'h11
`define SWR_MEM_CMD2      8'h12
`define SWR_MEM_CMD3      8'h13
`define SWR_MEM_CMD4      8'h14

// Memory organisation
`define SWR_MEM_BYTES     8192
`define SWR_PAGES         256
`define SWR_ERASED        8'hFF
`define SWR_PAGE_HI       12
`define SWR_PAGE_LO       5

// Timing
`define SWR_CLK_NS        10
`define SWR_VPP_PULSE_NS  500
`define SWR_VPP_CYC       16'((`SWR_VPP_PULSE_NS + `SWR_CLK_NS - 1) / `SWR_CLK_NS)
`define SWR_GAP_CYC       16'h0003
`define SWR_TMR_ZERO      16'h0000
`define SWR_BITS8         3'h7
`define SWR_BITS1         3'h0

`endif

// ==== include/swr_pkg.sv ====
// Shared types and the serial check-value step for the single-wire link.
`default_nettype none
`include "swr_link_regs.svh"
package swr_pkg;

  // Master command operations
  typedef enum logic [2:0] {
    SWR_OP_RST,
    SWR_OP_WR8,
    SWR_OP_RD8,
    SWR_OP_WR1,
    SWR_OP_RD1,
    SWR_OP_PGM
  } swr_op_t;

  // Device protocol states
  typedef enum {
    SD_IDLE,
    SD_ROMCMD,
    SD_RDROM,
    SD_MATCH,
    SD_SEARCH,
    SD_MEMCMD,
    SD_DONE
  } swr_dev_st_t;

  // Master sequencer states
  typedef enum {
    SM_IDLE,
    SM_GAP,
    SM_SLOT,
    SM_RST,
    SM_VPP
  } swr_mst_st_t;

  // One step of the check value, bit in at the top of a right shift
  function automatic logic [7:0] swr_crc_step(input logic [7:0] crc, input logic b);
    logic fb;
    fb = crc[0] ^ b;
    swr_crc_step = (crc >> 1) ^ (fb ? `SWR_CRC_POLY_REV : `SWR_CRC_ZERO);
  endfunction

  // Check value over the 56 identity bits, low bit first
  function automatic logic [7:0] swr_crc_calc(input logic [55:0] id);
    logic [7:0] acc;
    acc = `SWR_CRC_ZERO;
    for (int i = 0; i < `SWR_ID_BITS; i++) begin
      acc = swr_crc_step(acc, id[i]);
    end
    swr_crc_calc = acc;
  endfunction

endpackage
`default_nettype wire

// ==== include/swr_link_if.sv ====
// Single-wire link between bus master and identity device, wired-AND line.
`timescale 1ns/100ps
`default_nettype none
interface swr_link_if;
  logic bus_rst;    // Reset pulse from master
  logic slot_w;     // Master write slot
  logic slot_r;     // Master read slot
  logic dq_m_o;     // Master line value
  logic dq_m_oe_n;  // Master drives when low
  logic dq_s_o;     // Device line value
  logic dq_s_oe_n;  // Device drives when low
  logic vpp;        // Programming voltage on line
  logic dq;         // Resolved line level

  // Pulled high, any driver can pull low
  assign dq = (dq_m_oe_n | dq_m_o) & (dq_s_oe_n | dq_s_o);

  modport master (output bus_rst, output slot_w, output slot_r, output dq_m_o,
                  output dq_m_oe_n, output vpp, input dq);
  modport device (input bus_rst, input slot_w, input slot_r, output dq_s_o,
                  output dq_s_oe_n, input vpp, input dq);
endinterface
`default_nettype wire

// ==== rtl/swr_mst.sv ====
// Bus master end: byte and bit slots, reset pulse, programming pulse.
`timescale 1ns/100ps
`default_nettype none
`include "swr_link_regs.svh"
module swr_mst (
  input  wire logic            CLK,
  input  wire logic            RESET_N,
  swr_link_if.master           LNK,
  input  wire logic            CMD_VALID,
  input  wire swr_pkg::swr_op_t CMD_OP,
  input  wire logic [7:0]      CMD_DATA,
  output logic                 CMD_READY,
  output logic                 RSP_VALID,
  output logic [7:0]           RSP_DATA,
  input  wire logic            CRC_CLR,
  output logic [7:0]           CRC_VAL,
  output logic                 CRC_ZERO
);
  swr_pkg::swr_mst_st_t st_r;     // Sequencer state
  swr_pkg::swr_op_t     op_r;     // Operation in progress
  logic [7:0]           sh_r;     // Bit shifter, low bit first
  logic [2:0]           nb_r;     // Bits still to go after the current one
  logic [15:0]          tmr_r;    // Gap and pulse timer
  logic [7:0]           rsp_r;    // Answer byte
  logic                 rsp_v_r;  // Answer strobe
  logic [7:0]           crc_r;    // Check accumulator

  // Decoded operation kind
  wire  op_rd     = (op_r == swr_pkg::SWR_OP_RD8) || (op_r == swr_pkg::SWR_OP_RD1);
  wire  in_slot   = (st_r == swr_pkg::SM_SLOT);
  wire  go        = CMD_VALID && CMD_READY;
  wire  one_bit   = (CMD_OP == swr_pkg::SWR_OP_WR1) || (CMD_OP == swr_pkg::SWR_OP_RD1);
  wire  [7:0] crc_base = CRC_CLR ? `SWR_CRC_ZERO : crc_r;  // Clear first, then step
  wire  [7:0] rd_byte  = {LNK.dq, sh_r[7:1]};              // Low bit arrives first

  // Link drive, combinational handshake
  assign LNK.bus_rst   = (st_r == swr_pkg::SM_RST);
  assign LNK.slot_w    = in_slot && !op_rd;
  assign LNK.slot_r    = in_slot && op_rd;
  assign LNK.dq_m_o    = sh_r[0];                           // Low bit first
  assign LNK.dq_m_oe_n = !(in_slot && !op_rd);
  assign LNK.vpp       = (st_r == swr_pkg::SM_VPP);         // Brief high-voltage pulse
  assign CMD_READY     = (st_r == swr_pkg::SM_IDLE);
  assign RSP_VALID     = rsp_v_r;
  assign RSP_DATA      = rsp_r;
  assign CRC_VAL       = crc_r;
  assign CRC_ZERO      = (crc_r == `SWR_CRC_ZERO);          // Whole identity checks to zero

  // Check accumulator over every bit read
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      crc_r <= `SWR_CRC_ZERO;
    end else if (LNK.slot_r) begin
      crc_r <= swr_pkg::swr_crc_step(crc_base, LNK.dq);
    end else begin
      crc_r <= crc_base;
    end
  end

  // Sequencer
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r    <= swr_pkg::SM_IDLE;
      op_r    <= swr_pkg::SWR_OP_RST;
      sh_r    <= `SWR_CRC_ZERO;
      nb_r    <= `SWR_BITS1;
      tmr_r   <= `SWR_TMR_ZERO;
      rsp_r   <= `SWR_CRC_ZERO;
      rsp_v_r <= 1'b0;
    end else begin
      rsp_v_r <= 1'b0;
      case (st_r)
        swr_pkg::SM_IDLE: begin
          if (go) begin
            op_r  <= CMD_OP;
            sh_r  <= CMD_DATA;
            nb_r  <= one_bit ? `SWR_BITS1 : `SWR_BITS8;
            tmr_r <= (CMD_OP == swr_pkg::SWR_OP_PGM) ? `SWR_VPP_CYC : `SWR_GAP_CYC;
            case (CMD_OP)
              swr_pkg::SWR_OP_RST: st_r <= swr_pkg::SM_RST;
              swr_pkg::SWR_OP_PGM: st_r <= swr_pkg::SM_VPP;
              default:             st_r <= swr_pkg::SM_GAP;
            endcase
          end
        end
        swr_pkg::SM_GAP: begin
          tmr_r <= tmr_r - 16'h0001;
          if (tmr_r == `SWR_TMR_ZERO) begin
            st_r <= swr_pkg::SM_SLOT;
          end
        end
        swr_pkg::SM_SLOT: begin
          sh_r <= rd_byte;
          if (nb_r == `SWR_BITS1) begin
            st_r    <= swr_pkg::SM_IDLE;
            rsp_v_r <= op_rd;
            rsp_r   <= (op_r == swr_pkg::SWR_OP_RD1) ? {7'h00, LNK.dq} : rd_byte;
          end else begin
            nb_r  <= nb_r - 3'h1;
            tmr_r <= `SWR_GAP_CYC;
            st_r  <= swr_pkg::SM_GAP;
          end
        end
        swr_pkg::SM_VPP: begin
          tmr_r <= tmr_r - 16'h0001;
          if (tmr_r == 16'h0001) begin
            st_r <= swr_pkg::SM_IDLE;
          end
        end
        swr_pkg::SM_RST: begin
          st_r <= swr_pkg::SM_IDLE;
        end
        default: begin
          st_r <= swr_pkg::SM_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== verification/swr_link_asserts.sv ====
// Checker for slot, drive and programming-pulse behaviour on the single-wire link.
`timescale 1ns/100ps
`default_nettype none
`include "swr_link_regs.svh"
module swr_link_asserts (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic bus_rst,
  input wire logic slot_w,
  input wire logic slot_r,
  input wire logic dq_m_o,
  input wire logic dq_m_oe_n,
  input wire logic dq_s_o,
  input wire logic dq_s_oe_n,
  input wire logic vpp,
  input wire logic dq
);
  localparam int VPP_CYC = `SWR_VPP_CYC;  // Programming pulse length

  logic [15:0] vpp_cnt_r;    // Cycles the pulse has stood
  logic [15:0] vpp_cnt_nxt;  // Next pulse count

  // Count while the pulse stands, clear otherwise
  assign vpp_cnt_nxt = vpp ? vpp_cnt_r + 16'h0001 : 16'h0000;

  // Pulse length counter
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      vpp_cnt_r <= 16'h0000;
    end else begin
      vpp_cnt_r <= vpp_cnt_nxt;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  // Quiet line between two slots
  sequence s_quiet;
    !(slot_w || slot_r) [*3];
  endsequence

  // Pulse holds at least eight cycles
  sequence s_vpp_hold;
    vpp [*8];
  endsequence

  a_slot_one_kind: assert property (!(slot_w && slot_r))
    else $error("write and read slot together");
  a_slot_spacing: assert property ((slot_w || slot_r) |=> s_quiet)
    else $error("slots too close");
  a_write_master_drives: assert property (slot_w |-> !dq_m_oe_n)
    else $error("master not driving in write slot");
  a_read_master_off: assert property (slot_r |-> dq_m_oe_n)
    else $error("master driving in read slot");
  a_dev_drive_slot: assert property (!dq_s_oe_n |-> slot_r)
    else $error("device drives outside read slot");
  a_rst_one_cycle: assert property (bus_rst |=> !bus_rst && !slot_w && !slot_r)
    else $error("bus reset pulse too long");
  a_vpp_quiet_bus: assert property (vpp |-> !(slot_w || slot_r || bus_rst))
    else $error("traffic during programming pulse");
  a_vpp_min_hold: assert property ($rose(vpp) |-> s_vpp_hold)
    else $error("programming pulse too short");
  a_vpp_exact_len: assert property ($fell(vpp) |-> vpp_cnt_r == 16'(VPP_CYC))
    else $error("programming pulse length wrong");
endmodule
`default_nettype wire

// ==== verification/test_single_wire_rom_id_crc_front_end.sv ====
// Testbench joining master and device ends of the single-wire identity link.
`timescale 1ns/100ps
`default_nettype none
`include "swr_link_regs.svh"
module test_single_wire_rom_id_crc_front_end;
  localparam logic [7:0]  FAM = 8'h3C;            // Arbitrary family value
  localparam logic [47:0] SER = 48'h5A5A1234C0DE; // Arbitrary serial value
  localparam logic [7:0]  MCODES [5] = '{`SWR_MEM_READ, `SWR_MEM_CMD1, `SWR_MEM_CMD2,
                                         `SWR_MEM_CMD3, `SWR_MEM_CMD4};  // Memory commands

  logic             clk, reset_n, cmd_valid, crc_clr, prg_stb, wp_stb;     // Bench-driven controls
  swr_pkg::swr_op_t cmd_op;                                               // Master operation
  logic [7:0]       cmd_data, prg_data, rsp_data, crc_val, mem_cmd, rd_data;
  logic [12:0]      prg_addr, rd_addr;                                    // Memory addresses
  logic             cmd_ready, rsp_valid, crc_zero, id_ok, od_mode;       // Design flags
  logic             vpp_det, mem_ok, mem_cmd_stb, prg_done;               // Device flags
  logic [7:0]       wbits, rbits;                                         // Bits seen on the wire
  logic [63:0]      rom_id;                                               // Expected identity
  int               num_errors, comparisons, stb_cnt, prg_cnt;            // Counters

  swr_link_if lnk ();

  swr_mst swr_mst_inst (.CLK(clk), .RESET_N(reset_n), .LNK(lnk), .CMD_VALID(cmd_valid),
    .CMD_OP(cmd_op), .CMD_DATA(cmd_data), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid),
    .RSP_DATA(rsp_data), .CRC_CLR(crc_clr), .CRC_VAL(crc_val), .CRC_ZERO(crc_zero));

  swr_dev #(.FAMILY(FAM), .SERIAL(SER)) swr_dev_inst (.CLK(clk), .RESET_N(reset_n), .LNK(lnk),
    .ID_OK(id_ok), .OD_MODE(od_mode), .VPP_DET(vpp_det), .MEM_OK(mem_ok), .MEM_CMD(mem_cmd),
    .MEM_CMD_STB(mem_cmd_stb), .PRG_STB(prg_stb), .WP_STB(wp_stb), .PRG_ADDR(prg_addr),
    .PRG_DATA(prg_data), .PRG_DONE(prg_done), .RD_ADDR(rd_addr), .RD_DATA(rd_data));

  swr_link_asserts swr_link_asserts_inst (.CLK(clk), .RESET_N(reset_n), .bus_rst(lnk.bus_rst),
    .slot_w(lnk.slot_w), .slot_r(lnk.slot_r), .dq_m_o(lnk.dq_m_o), .dq_m_oe_n(lnk.dq_m_oe_n),
    .dq_s_o(lnk.dq_s_o), .dq_s_oe_n(lnk.dq_s_oe_n), .vpp(lnk.vpp), .dq(lnk.dq));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Wire monitor, low bit first lands at bit 0
  always @(posedge clk) begin
    if (lnk.slot_w === 1'b1) wbits <= {lnk.dq, wbits[7:1]};
    if (lnk.slot_r === 1'b1) rbits <= {lnk.dq, rbits[7:1]};
    if (mem_cmd_stb === 1'b1) stb_cnt <= stb_cnt + 1;
    if (prg_done === 1'b1) prg_cnt <= prg_cnt + 1;
  end

  // Serial check value, reference model
  function automatic logic [7:0] ref_crc(input logic [55:0] id);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      c = (c >> 1) ^ ((c[0] ^ id[i]) ? 8'h8C : 8'h00);
    end
    return c;
  endfunction

  // Byte comparison
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Flag comparison
  task automatic chk1(input logic got, input logic exp, input string msg);
    chk8({7'h00, got}, {7'h00, exp}, msg);
  endtask

  // One master command, held until taken
  task automatic cmd(input swr_pkg::swr_op_t op, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_data <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 2000);
    cmd_valid <= 1'b0;
    q = 8'h00;
    if (op == swr_pkg::SWR_OP_PGM) return;
    for (n = 0; n < 2000; n++) begin
      @(posedge clk);
      #1;
      if (op == swr_pkg::SWR_OP_RD8 ? rsp_valid === 1'b1 : cmd_ready === 1'b1) break;
    end
    q = rsp_data;
    chk1(n < 2000, 1'b1, "command completes");
  endtask

  // Bus reset then an identity command byte
  task automatic rom(input logic [7:0] c);
    logic [7:0] q;
    cmd(swr_pkg::SWR_OP_RST, 8'h00, q);
    cmd(swr_pkg::SWR_OP_WR8, c, q);
    chk8(wbits, c, "command byte on wire");
  endtask

  // Program one byte, or protect the page that holds it
  task automatic prg(input logic [12:0] a, input logic [7:0] d, input logic wp, input logic hv);
    logic [7:0] q;
    int n;
    if (hv) begin
      cmd(swr_pkg::SWR_OP_PGM, 8'h00, q);
      for (n = 0; n < 10 && vpp_det !== 1'b1; n++) @(posedge clk);
      chk1(vpp_det, 1'b1, "programming voltage seen");
    end
    @(posedge clk);
    prg_addr <= a;
    prg_data <= d;
    prg_stb <= !wp;
    wp_stb <= wp;
    @(posedge clk);
    prg_stb <= 1'b0;
    wp_stb <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Read one memory byte, one cycle latency
  task automatic rdm(input logic [12:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_addr <= a;
    repeat (2) @(posedge clk);
    #1;
    chk8(rd_data, e, "memory byte");
  endtask

  // Identity self-check
  task automatic t_id();
    for (int n = 0; n < 100 && id_ok !== 1'b1; n++) @(posedge clk);
    chk1(id_ok, 1'b1, "identity self-check");
    $display("identity test done");
  endtask

  // Read the whole identity
  task automatic t_read();
    logic [7:0] q;
    rom(`SWR_ROM_READ);
    @(posedge clk);
    crc_clr <= 1'b1;
    @(posedge clk);
    crc_clr <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      cmd(swr_pkg::SWR_OP_RD8, 8'h00, q);
      repeat (2) @(posedge clk);
      chk8(q, rom_id[8*i +: 8], "identity byte");
      chk8(rbits, rom_id[8*i +: 8], "identity byte on wire");
      if (i == 6) chk8(crc_val, rom_id[63:56], "check value");
    end
    chk1(crc_zero, 1'b1, "remainder after check byte");
    $display("read test done");
  endtask

  // Memory commands gated by an identity command
  task automatic t_gate();
    logic [7:0] q;
    int n;
    n = stb_cnt;
    rom(`SWR_MEM_READ);
    cmd(swr_pkg::SWR_OP_WR8, `SWR_MEM_READ, q);
    repeat (3) @(posedge clk);
    chk1(mem_ok, 1'b0, "memory open without identity");
    chk8(8'(stb_cnt - n), 8'h00, "memory command taken early");
    for (int i = 0; i < 5; i++) begin
      rom(`SWR_ROM_SKIP);
      chk1(mem_ok, 1'b1, "skip opens memory");
      cmd(swr_pkg::SWR_OP_WR8, MCODES[i], q);
      repeat (3) @(posedge clk);
      chk8(mem_cmd, MCODES[i], "memory command code");
      chk8(8'(stb_cnt - n), 8'(i + 1), "memory command strobes");
    end
    $display("gating test done");
  endtask

  // Match, one byte optionally spoiled
  task automatic t_match(input logic [7:0] c, input logic [7:0] flip);
    logic [7:0] q;
    rom(c);
    for (int i = 0; i < 8; i++) begin
      cmd(swr_pkg::SWR_OP_WR8, rom_id[8*i +: 8] ^ (i == 3 ? flip : 8'h00), q);
    end
    repeat (3) @(posedge clk);
    chk1(mem_ok, flip == 8'h00, "match result");
    $display("match test done");
  endtask

  // Search: bit, complement, chosen bit
  task automatic t_srch();
    logic [7:0] q, p;
    rom(`SWR_ROM_SEARCH);
    for (int i = 0; i < 64; i++) begin
      cmd(swr_pkg::SWR_OP_RD1, 8'h00, q);
      cmd(swr_pkg::SWR_OP_RD1, 8'h00, p);
      chk8({q[0], p[0], 6'h00}, {rom_id[i], !rom_id[i], 6'h00}, "search bits");
      cmd(swr_pkg::SWR_OP_WR1, q, q);
    end
    chk1(mem_ok, 1'b1, "search match");
    $display("search test done");
  endtask

  // Add-only programming and protection
  task automatic t_prog();
    rom(`SWR_ROM_SKIP);
    prg(13'h0040, 8'h00, 1'b0, 1'b0);
    rdm(13'h0040, 8'hFF);
    prg(13'h0040, 8'h5A, 1'b0, 1'b1);
    rdm(13'h0040, 8'h5A);
    prg(13'h0040, 8'hF0, 1'b0, 1'b1);
    rdm(13'h0040, 8'h50);
    prg(13'h0041, 8'h00, 1'b1, 1'b1);
    prg(13'h0041, 8'h00, 1'b0, 1'b1);
    rdm(13'h0041, 8'hFF);
    prg(13'h0060, 8'h0F, 1'b0, 1'b1);
    rdm(13'h0060, 8'h0F);
    chk8(8'(prg_cnt), 8'h03, "programs done");
    $display("programming test done");
  endtask

  // Fast-mode commands
  task automatic t_od();
    chk1(od_mode, 1'b0, "fast mode before command");
    t_match(`SWR_ROM_OD_MATCH, 8'h00);
    chk1(od_mode, 1'b1, "fast mode after match");
    rom(`SWR_ROM_OD_SKIP);
    chk1(mem_ok, 1'b1, "fast skip opens memory");
    $display("fast mode test done");
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    stop_test();
  end

  // Main sequence
  initial begin
    {reset_n, cmd_valid, crc_clr, prg_stb, wp_stb} = 5'h00;
    cmd_op = swr_pkg::SWR_OP_RST;
    {cmd_data, prg_data, prg_addr, rd_addr} = 42'h0;
    {num_errors, comparisons, stb_cnt, prg_cnt} = '0;
    {wbits, rbits} = 16'h0000;
    rom_id = {ref_crc({SER, FAM}), SER, FAM};
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_id();
    t_read();
    t_gate();
    t_match(`SWR_ROM_MATCH, 8'h00);
    t_match(`SWR_ROM_MATCH, 8'h10);
    t_srch();
    t_prog();
    t_od();
    stop_test();
  end
endmodule
`default_nettype wire
